/* File: common/can_bridge_pkg.sv */
/*
 Constants for the serial/CAN bridge: the configuration word layout, the
 power-up defaults, the terminator codes, the byte limits and the receive states.
 Assumes the speed codes are decoded by the serial and CAN controllers outside.
*/
package can_bridge_pkg;
	localparam int ID_W = 29;
	localparam logic [28:0] STD_ID_MASK = 29'h00007ff;
	localparam logic [28:0] EXT_ID_MASK = 29'h1fffffff;
	// configuration word layout
	localparam int F_BAUD_LSB = 0;
	localparam int F_DATA_LSB = 4;
	localparam int F_STOP = 8;
	localparam int F_PARITY_LSB = 9;
	localparam int F_CHECKSUM = 11;
	localparam int F_ERR_RESP = 12;
	localparam int F_EXT = 13;
	localparam int F_CAN_BAUD_LSB = 14;
	localparam int F_CODE_LSB = 18;
	localparam int F_MASK_LSB = 47;
	localparam int F_PAIR = 76;
	localparam int F_TERM_LSB = 77;
	localparam int F_PAIR_ID_LSB = 80;
	localparam int F_RESP_ID = 109;
	localparam int CFG_W = 110;
	// speed codes as understood by the outside controllers
	localparam logic [3:0] SER_BAUD_115200 = 4'h9;
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] CAN_BAUD_125K = 4'h3;
	localparam logic [28:0] PAIR_ID_DEFAULT = 29'h0000001;
	localparam logic [CFG_W-1:0] CFG_DEFAULT =
		(CFG_W'(SER_BAUD_115200) << F_BAUD_LSB) |
		(CFG_W'(DATA_BITS_8) << F_DATA_LSB) |
		(CFG_W'(CAN_BAUD_125K) << F_CAN_BAUD_LSB) |
		(CFG_W'(PAIR_ID_DEFAULT) << F_PAIR_ID_LSB);
	// end-of-command choices
	localparam logic [2:0] TERM_NONE = 3'h0;
	localparam logic [2:0] TERM_RETURN = 3'h1;
	localparam logic [2:0] TERM_LINEFEED = 3'h2;
	localparam logic [2:0] TERM_RETURN_THEN_LINEFEED = 3'h3;
	localparam logic [2:0] TERM_LINEFEED_THEN_RETURN = 3'h4;
	localparam logic [7:0] CHAR_RETURN = 8'h0d;
	localparam logic [7:0] CHAR_LINEFEED = 8'h0a;
	localparam int FRAME_BYTES = 8;
	localparam int HOLD_DEPTH = 72;
	localparam int HOLD_AW = 7;
	localparam int PAIR_IDLE_CYCLES = 400;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_DATA = 3'b010,
		RX_DUMP = 3'b100
	} rx_state_e;
endpackage

/* File: src/pair_byte_store.sv */
/*
 Byte store that holds received pair-mode bytes until the end character.
 Assumes one write and one read port on the same clock; read data is registered.
*/
`timescale 1ns/1ps
module pair_byte_store #(
	parameter int DEPTH = 72,
	parameter int AW = 7
) (
	input wire logic mclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* File: src/can_serial_bridge.sv */
/*
 Serial/CAN bridge core: acceptance filter, pair-connection byte mapping in both
 directions, error reply request, configuration set with defaults and store.
 Assumes CAN and serial framing, command parsing and the nonvolatile memory sit
 outside and talk through valid/ready handshakes.
*/
`timescale 1ns/1ps
module can_serial_bridge #(
	parameter int IDLE_FLUSH_CYCLES = can_bridge_pkg::PAIR_IDLE_CYCLES,
	parameter logic [7:0] ERROR_CODE_BYTE = 8'h3f
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic init_switch,
	input wire logic cfg_load,
	input wire logic [can_bridge_pkg::CFG_W-1:0] cfg_wdata,
	input wire logic restore_defaults,
	input wire logic store_request,
	output logic [can_bridge_pkg::CFG_W-1:0] cfg_q,
	input wire logic nv_rd_valid,
	input wire logic [can_bridge_pkg::CFG_W-1:0] nv_rd_data,
	output logic nv_wr_valid,
	input wire logic nv_wr_ready,
	output logic [can_bridge_pkg::CFG_W-1:0] nv_wr_data,
	output logic [3:0] ser_baud_sel,
	output logic checksum_enable,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic rx_extended,
	input wire logic [28:0] rx_id,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	output logic fwd_valid,
	input wire logic fwd_ready,
	output logic fwd_extended,
	output logic [28:0] fwd_id,
	output logic [3:0] fwd_dlc,
	output logic [63:0] fwd_data,
	input wire logic ser_rx_valid,
	output logic ser_rx_ready,
	input wire logic [7:0] ser_rx_data,
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic [7:0] cmd_data,
	input wire logic cmd_error,
	output logic ser_tx_valid,
	input wire logic ser_tx_ready,
	output logic [7:0] ser_tx_data,
	output logic can_tx_valid,
	input wire logic can_tx_ready,
	output logic can_tx_extended,
	output logic [28:0] can_tx_id,
	output logic [3:0] can_tx_dlc,
	output logic [63:0] can_tx_data
);
	function automatic logic term_hit(input logic [2:0] t, input logic [7:0] p, input logic [7:0] c);
		case (t)
			can_bridge_pkg::TERM_RETURN: term_hit = (c == can_bridge_pkg::CHAR_RETURN);
			can_bridge_pkg::TERM_LINEFEED: term_hit = (c == can_bridge_pkg::CHAR_LINEFEED);
			can_bridge_pkg::TERM_RETURN_THEN_LINEFEED: term_hit = (p == can_bridge_pkg::CHAR_RETURN) &&
				(c == can_bridge_pkg::CHAR_LINEFEED);
			can_bridge_pkg::TERM_LINEFEED_THEN_RETURN: term_hit = (p == can_bridge_pkg::CHAR_LINEFEED) &&
				(c == can_bridge_pkg::CHAR_RETURN);
			default: term_hit = 1'b0;
		endcase
	endfunction

	can_bridge_pkg::rx_state_e state_q;
	logic init_q, init_seen_q;
	logic fwd_valid_q, err_pend_q, rd_pend_q, ser_tx_valid_q, cmd_valid_q, can_tx_valid_q;
	logic [95:0] q_q, q_c;
	logic [3:0] qn_q, qn_c, dlc_c, tx_cnt_q;
	logic [7:0] last_q, tx_last_q, mem_rd;
	logic [6:0] wcnt_q, rptr_q;
	logic [31:0] id32, id_be;
	logic [2:0] pre;
	logic [15:0] idle_q;

	wire pair = cfg_q[can_bridge_pkg::F_PAIR];
	wire ext_mode = cfg_q[can_bridge_pkg::F_EXT];
	wire err_resp = cfg_q[can_bridge_pkg::F_ERR_RESP];
	wire [2:0] term = cfg_q[can_bridge_pkg::F_TERM_LSB +: 3];
	wire [28:0] code = cfg_q[can_bridge_pkg::F_CODE_LSB +: can_bridge_pkg::ID_W];
	wire [28:0] mask = cfg_q[can_bridge_pkg::F_MASK_LSB +: can_bridge_pkg::ID_W];
	wire [28:0] pair_id = cfg_q[can_bridge_pkg::F_PAIR_ID_LSB +: can_bridge_pkg::ID_W];
	wire resp_id = pair && cfg_q[can_bridge_pkg::F_RESP_ID];
	wire term_on = pair && (term != can_bridge_pkg::TERM_NONE);
	wire [28:0] id_width = ext_mode ? can_bridge_pkg::EXT_ID_MASK : can_bridge_pkg::STD_ID_MASK;
	// only masked positions within the identifier width are compared, and every one of them must match
	wire accept = (((rx_id ^ code) & mask & id_width) == 29'h0);
	wire take = rx_valid && rx_ready && accept;
	wire out_free = !ser_tx_valid_q || ser_tx_ready;
	wire [7:0] cur = q_q[7:0];
	wire data_step = (state_q == can_bridge_pkg::RX_DATA) && (term_on || out_free);
	wire flush_hold = term_on && (term_hit(term, last_q, cur) || wcnt_q == 7'(can_bridge_pkg::HOLD_DEPTH - 1));
	wire rd_en = (state_q == can_bridge_pkg::RX_DUMP) && !rd_pend_q && (rptr_q != wcnt_q);
	wire send_dump = (state_q == can_bridge_pkg::RX_DUMP) && rd_pend_q && out_free;
	wire send_direct = data_step && !term_on;
	wire send_err = err_pend_q && out_free && !send_dump && !send_direct;
	wire ser_take = ser_rx_valid && ser_rx_ready;
	wire tx_full = (tx_cnt_q == 4'(can_bridge_pkg::FRAME_BYTES - 1));
	wire tx_term = term_on && term_hit(term, tx_last_q, ser_rx_data);
	wire idle_flush = !can_tx_valid_q && (tx_cnt_q != 4'h0) && (idle_q == 16'(IDLE_FLUSH_CYCLES - 1));

	assign rx_ready = (state_q == can_bridge_pkg::RX_IDLE) && !fwd_valid_q;
	assign fwd_valid = fwd_valid_q;
	assign ser_tx_valid = ser_tx_valid_q;
	assign cmd_valid = cmd_valid_q;
	assign can_tx_valid = can_tx_valid_q;
	assign ser_rx_ready = pair ? !can_tx_valid_q : (!cmd_valid_q || cmd_ready);
	assign ser_baud_sel = init_q ? can_bridge_pkg::SER_BAUD_115200 : cfg_q[can_bridge_pkg::F_BAUD_LSB +: 4];
	// the parser outside verifies the trailing checksum the host must append
	assign checksum_enable = cfg_q[can_bridge_pkg::F_CHECKSUM];

	// the switch is a strap: caught once, on the first edge after reset release
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			init_q <= 1'b0;
			init_seen_q <= 1'b0;
		end else if (!init_seen_q) begin
			init_q <= init_switch;
			init_seen_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_q <= can_bridge_pkg::CFG_DEFAULT;
		end else if (restore_defaults) begin
			cfg_q <= can_bridge_pkg::CFG_DEFAULT;
		end else if (cfg_load) begin
			cfg_q <= cfg_wdata;
		end else if (nv_rd_valid) begin
			cfg_q <= nv_rd_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			nv_wr_valid <= 1'b0;
			nv_wr_data <= '0;
		end else if (store_request && !nv_wr_valid) begin
			nv_wr_valid <= 1'b1;
			nv_wr_data <= cfg_q;
		end else if (nv_wr_ready) begin
			nv_wr_valid <= 1'b0;
		end
	end

	// frame bytes queued lowest first: optional id bytes, then the data field
	always_comb begin
		id32 = {3'b000, rx_id};
		dlc_c = (rx_dlc > 4'd8) ? 4'd8 : rx_dlc;
		if (!resp_id) begin
			pre = 3'd0;
			id_be = 32'h0;
		end else if (rx_extended) begin
			pre = 3'd4;
			id_be = {id32[7:0], id32[15:8], id32[23:16], id32[31:24]};
		end else begin
			pre = 3'd2;
			id_be = {16'h0, id32[7:0], 5'h00, id32[10:8]};
		end
		q_c = ({32'h0, rx_data} << {pre, 3'b000}) | {64'h0, id_be};
		qn_c = {1'b0, pre} + dlc_c;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fwd_valid_q <= 1'b0;
			fwd_extended <= 1'b0;
			fwd_id <= '0;
			fwd_dlc <= '0;
			fwd_data <= '0;
		end else if (take && !pair) begin
			fwd_valid_q <= 1'b1;
			fwd_extended <= rx_extended;
			fwd_id <= rx_id;
			fwd_dlc <= rx_dlc;
			fwd_data <= rx_data;
		end else if (fwd_ready) begin
			fwd_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= can_bridge_pkg::RX_IDLE;
			q_q <= '0;
			qn_q <= '0;
			last_q <= '0;
			wcnt_q <= '0;
			rptr_q <= '0;
			rd_pend_q <= 1'b0;
		end else begin
			unique case (state_q)
				can_bridge_pkg::RX_IDLE: begin
					if (take && pair && qn_c != 4'h0) begin
						q_q <= q_c;
						qn_q <= qn_c;
						state_q <= can_bridge_pkg::RX_DATA;
					end
				end
				can_bridge_pkg::RX_DATA: begin
					if (data_step) begin
						q_q <= q_q >> 8;
						qn_q <= qn_q - 4'h1;
						last_q <= cur;
						if (term_on) begin
							wcnt_q <= wcnt_q + 7'h1;
						end
						if (flush_hold) begin
							state_q <= can_bridge_pkg::RX_DUMP;
						end else if (qn_q == 4'h1) begin
							state_q <= can_bridge_pkg::RX_IDLE;
						end
					end
				end
				can_bridge_pkg::RX_DUMP: begin
					if (rd_en) begin
						rd_pend_q <= 1'b1;
					end else if (send_dump) begin
						rd_pend_q <= 1'b0;
						rptr_q <= rptr_q + 7'h1;
					end else if (!rd_pend_q) begin
						// whole held message is out; resume any bytes left in the frame
						wcnt_q <= '0;
						rptr_q <= '0;
						last_q <= '0;
						state_q <= (qn_q != 4'h0) ? can_bridge_pkg::RX_DATA : can_bridge_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end

	pair_byte_store #(
		.DEPTH(can_bridge_pkg::HOLD_DEPTH),
		.AW(can_bridge_pkg::HOLD_AW)
	) u_hold (
		.mclk(mclk),
		.wr_en(data_step && term_on),
		.wr_addr(wcnt_q),
		.wr_data(cur),
		.rd_en(rd_en),
		.rd_addr(rptr_q),
		.rd_data(mem_rd)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ser_tx_valid_q <= 1'b0;
			ser_tx_data <= '0;
		end else if (send_dump) begin
			ser_tx_valid_q <= 1'b1;
			ser_tx_data <= mem_rd;
		end else if (send_direct) begin
			ser_tx_valid_q <= 1'b1;
			ser_tx_data <= cur;
		end else if (send_err) begin
			ser_tx_valid_q <= 1'b1;
			ser_tx_data <= ERROR_CODE_BYTE;
		end else if (ser_tx_ready) begin
			ser_tx_valid_q <= 1'b0;
		end
	end

	// a new error in the cycle of the reply still leaves one pending
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			err_pend_q <= 1'b0;
		end else begin
			err_pend_q <= (err_pend_q && !send_err) || (cmd_error && err_resp && !pair);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmd_valid_q <= 1'b0;
			cmd_data <= '0;
		end else if (ser_take && !pair) begin
			cmd_valid_q <= 1'b1;
			cmd_data <= ser_rx_data;
		end else if (cmd_ready) begin
			cmd_valid_q <= 1'b0;
		end
	end

	// pair transmit: fills a data field, sent when full, at the end character or after a pause
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			can_tx_valid_q <= 1'b0;
			can_tx_extended <= 1'b0;
			can_tx_id <= '0;
			can_tx_dlc <= '0;
			can_tx_data <= '0;
			tx_cnt_q <= '0;
			tx_last_q <= '0;
			idle_q <= '0;
		end else begin
			if (can_tx_valid_q && can_tx_ready) begin
				can_tx_valid_q <= 1'b0;
			end
			if (ser_take && pair) begin
				can_tx_data[{tx_cnt_q[2:0], 3'b000} +: 8] <= ser_rx_data;
				tx_last_q <= ser_rx_data;
				idle_q <= '0;
				if (tx_full || tx_term) begin
					can_tx_valid_q <= 1'b1;
					can_tx_dlc <= tx_cnt_q + 4'h1;
					can_tx_id <= pair_id & id_width;
					can_tx_extended <= ext_mode;
					tx_cnt_q <= '0;
				end else begin
					tx_cnt_q <= tx_cnt_q + 4'h1;
				end
			end else if (idle_flush) begin
				can_tx_valid_q <= 1'b1;
				can_tx_dlc <= tx_cnt_q;
				can_tx_id <= pair_id & id_width;
				can_tx_extended <= ext_mode;
				tx_cnt_q <= '0;
				idle_q <= '0;
			end else if (tx_cnt_q != 4'h0 && !can_tx_valid_q) begin
				idle_q <= idle_q + 16'h1;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	filter_drop_a: assert property (rx_valid && rx_ready && !accept |=>
		state_q == can_bridge_pkg::RX_IDLE && !fwd_valid_q) else $error("rejected frame was kept");
	mask_zero_a: assert property (rx_valid && mask == 29'h0 |-> accept) else $error("zero mask rejected");
	exact_id_a: assert property (rx_valid && !ext_mode && mask[10:0] == 11'h7ff && code[10:0] == 11'h123
		|-> accept == (rx_id[10:0] == 11'h123)) else $error("exact id filter wrong");
	range_id_a: assert property (rx_valid && !ext_mode && mask[10:0] == 11'h7c0 && code[10:6] == 5'h04
		|-> accept == (rx_id[10:0] >= 11'h100 && rx_id[10:0] <= 11'h13f)) else $error("range filter wrong");
	std_width_a: assert property (rx_valid && !ext_mode && mask[10:0] == 11'h0 |-> accept)
		else $error("upper id bits used in standard mode");
	err_quiet_a: assert property (!err_pend_q && cmd_error && !err_resp |=> !err_pend_q)
		else $error("error reply while disabled");
	pair_fill_a: assert property (ser_take && pair && !tx_full && !tx_term |=>
		tx_cnt_q == $past(tx_cnt_q) + 4'h1 && !cmd_valid_q) else $error("pair byte not packed");
	frame_map_a: assert property (take && pair && qn_c != 4'h0 |=>
		state_q == can_bridge_pkg::RX_DATA && q_q[7:0] == $past(q_c[7:0])) else $error("frame not unpacked");
	defaults_a: assert property (restore_defaults |=> cfg_q == can_bridge_pkg::CFG_DEFAULT)
		else $error("defaults not restored");
	store_a: assert property (store_request && !nv_wr_valid |=> nv_wr_valid && nv_wr_data == $past(cfg_q))
		else $error("settings not stored");
	init_baud_a: assert property (init_q |-> ser_baud_sel == can_bridge_pkg::SER_BAUD_115200)
		else $error("config mode speed wrong");
	hold_limit_a: assert property ((wcnt_q <= 7'd72) and (!term_on && state_q == can_bridge_pkg::RX_DATA
		|-> wcnt_q == 7'd0)) else $error("hold buffer misuse");
endmodule

/* File: sim/far_side_model.sv */
/*
 Far side of the bridge: CAN node, serial host and nonvolatile store, acting as
 sinks that stall at random. Assumes the bridge holds every valid until ready.
*/
`timescale 1ns/1ps
module far_side_model (
	input wire logic mclk,
	input wire logic rst_n,
	output logic fwd_ready,
	output logic ser_tx_ready,
	output logic can_tx_ready,
	output logic cmd_ready,
	output logic nv_wr_ready
);
	logic [15:0] st_q;
	// stalls come from a free-running lfsr so readies drop at uneven points
	always_ff @(posedge mclk) begin
		if (!rst_n)
			st_q <= 16'hace1;
		else
			st_q <= {st_q[14:0], st_q[15] ^ st_q[13] ^ st_q[12] ^ st_q[10]};
	end
	assign fwd_ready = st_q[0] | st_q[1];
	assign ser_tx_ready = st_q[2] | st_q[3];
	assign can_tx_ready = st_q[4] | st_q[6];
	assign cmd_ready = st_q[5] | st_q[7];
	// store is slow: accepts a write about one cycle in four
	assign nv_wr_ready = st_q[8] & st_q[9];
endmodule

/* File: sim/test_serial_can_acceptance_and_pairing.sv */
/*
 Self-checking bench for the serial/CAN bridge core: filter, pair mode, error
 reply, defaults, store and speed forcing. Assumes far_side_model as sink.
*/
`timescale 1ns/1ps
module test_serial_can_acceptance_and_pairing;
	localparam int W = can_bridge_pkg::CFG_W;
	localparam logic [7:0] ERR = 8'h5a;
	logic mclk = 0, rst_n = 0, init_switch = 1, cfg_load = 0, restore_defaults = 0;
	logic store_request = 0, nv_rd_valid = 0, nv_wr_valid, nv_wr_ready, checksum_enable;
	logic [W-1:0] cfg_wdata = '0, nv_rd_data = '0, cfg_q, nv_wr_data, cur;
	logic rx_valid = 0, rx_ready, rx_extended = 0, fwd_valid, fwd_ready, fwd_extended;
	logic [28:0] rx_id = '0, fwd_id, can_tx_id, c;
	logic [3:0] rx_dlc = '0, fwd_dlc, can_tx_dlc, ser_baud_sel, dl;
	logic [63:0] rx_data = '0, fwd_data, can_tx_data, d;
	logic ser_rx_valid = 0, ser_rx_ready, cmd_valid, cmd_ready, cmd_error = 0;
	logic ser_tx_valid, ser_tx_ready, can_tx_valid, can_tx_ready, can_tx_extended;
	logic [7:0] ser_rx_data = '0, cmd_data, ser_tx_data;
	logic [31:0] seed = 32'h00016415;
	int failures = 0, cmp_count = 0, n;
	logic [97:0] fq[$], tq[$], tx;
	logic [7:0] sq[$], cq[$];

	can_serial_bridge #(.ERROR_CODE_BYTE(ERR)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .init_switch(init_switch), .cfg_load(cfg_load), .cfg_wdata(cfg_wdata),
		.restore_defaults(restore_defaults), .store_request(store_request), .cfg_q(cfg_q),
		.nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .nv_wr_valid(nv_wr_valid), .nv_wr_ready(nv_wr_ready),
		.nv_wr_data(nv_wr_data), .ser_baud_sel(ser_baud_sel), .checksum_enable(checksum_enable),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_extended(rx_extended), .rx_id(rx_id), .rx_dlc(rx_dlc),
		.rx_data(rx_data), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_extended(fwd_extended),
		.fwd_id(fwd_id), .fwd_dlc(fwd_dlc), .fwd_data(fwd_data), .ser_rx_valid(ser_rx_valid),
		.ser_rx_ready(ser_rx_ready), .ser_rx_data(ser_rx_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_data(cmd_data), .cmd_error(cmd_error), .ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready),
		.ser_tx_data(ser_tx_data), .can_tx_valid(can_tx_valid), .can_tx_ready(can_tx_ready),
		.can_tx_extended(can_tx_extended), .can_tx_id(can_tx_id), .can_tx_dlc(can_tx_dlc), .can_tx_data(can_tx_data)
	);
	far_side_model u_far (
		.mclk(mclk), .rst_n(rst_n), .fwd_ready(fwd_ready), .ser_tx_ready(ser_tx_ready),
		.can_tx_ready(can_tx_ready), .cmd_ready(cmd_ready), .nv_wr_ready(nv_wr_ready)
	);

	always #12.5 mclk = ~mclk;

	always @(posedge mclk) begin
		if (fwd_valid && fwd_ready) fq.push_back({fwd_extended, fwd_dlc, fwd_id, fwd_data});
		if (ser_tx_valid && ser_tx_ready) sq.push_back(ser_tx_data);
		if (cmd_valid && cmd_ready) cq.push_back(cmd_data);
		if (can_tx_valid && can_tx_ready) tq.push_back({can_tx_extended, can_tx_dlc, can_tx_id, can_tx_data});
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// identifier-wide slice of the generator, so no call silently drops bits
	function automatic logic [28:0] rid();
		return 29'(rnd());
	endfunction

	function automatic logic [W-1:0] mk(logic ext, logic [28:0] code, logic [28:0] mask, logic pair, logic err);
		logic [W-1:0] w;
		w = can_bridge_pkg::CFG_DEFAULT;
		w[can_bridge_pkg::F_BAUD_LSB+:4] = 4'h2;
		w[can_bridge_pkg::F_EXT] = ext;
		w[can_bridge_pkg::F_CODE_LSB+:29] = code;
		w[can_bridge_pkg::F_MASK_LSB+:29] = mask;
		w[can_bridge_pkg::F_PAIR] = pair;
		w[can_bridge_pkg::F_ERR_RESP] = err;
		w[can_bridge_pkg::F_CHECKSUM] = err;
		w[can_bridge_pkg::F_PAIR_ID_LSB+:29] = ~code;
		return w;
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			failures++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic setcfg(input logic [W-1:0] w);
		@(posedge mclk);
		cfg_load <= 1;
		cfg_wdata <= w;
		cur = w;
		@(posedge mclk);
		cfg_load <= 0;
		cfg_wdata <= ~w;
		#1 chk(cfg_q === w, "config load");
	endtask

	task automatic frame(input logic [28:0] id, input logic [3:0] len, input logic [63:0] dat);
		int k;
		@(posedge mclk);
		rx_valid <= 1;
		rx_extended <= cur[can_bridge_pkg::F_EXT];
		rx_id <= id;
		rx_dlc <= len;
		rx_data <= dat;
		k = 0;
		#1;
		while (rx_ready !== 1'b1 && k < 60) begin
			@(posedge mclk);
			#1 k++;
		end
		chk(k < 60, "frame not taken");
		@(posedge mclk);
		rx_valid <= 0;
		rx_id <= ~id;
		rx_data <= ~dat;
	endtask

	task automatic filt(input logic [28:0] id);
		logic e;
		logic [63:0] v;
		int k;
		e = ((id ^ cur[can_bridge_pkg::F_CODE_LSB+:29]) & cur[can_bridge_pkg::F_MASK_LSB+:29] &
			(cur[can_bridge_pkg::F_EXT] ? can_bridge_pkg::EXT_ID_MASK : can_bridge_pkg::STD_ID_MASK)) == '0;
		v = {rnd(), rnd()};
		frame(id, 4'h8, v);
		for (k = 0; k < 30 && fq.size() == 0; k++) @(posedge mclk);
		chk(fq.size() == int'(e), "filter decision");
		if (fq.size() > 0) begin
			tx = fq.pop_front();
			chk(tx === {cur[can_bridge_pkg::F_EXT], 4'h8, id, v}, "forwarded frame");
		end
		chk(sq.size() == 0, "reply on drop");
	endtask

	task automatic sbyte(input logic [7:0] b);
		int k;
		@(posedge mclk);
		ser_rx_valid <= 1;
		ser_rx_data <= b;
		k = 0;
		#1;
		while (ser_rx_ready !== 1'b1 && k < 60) begin
			@(posedge mclk);
			#1 k++;
		end
		@(posedge mclk);
		ser_rx_valid <= 0;
		ser_rx_data <= ~b;
	endtask

	task automatic pulse_err();
		@(posedge mclk);
		cmd_error <= 1;
		@(posedge mclk);
		cmd_error <= 0;
		for (n = 0; n < 40 && sq.size() == 0; n++) @(posedge mclk);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		#1 chk(cfg_q === can_bridge_pkg::CFG_DEFAULT, "reset set");
		setcfg(mk(0, rid(), '0, 0, 0));
		chk(ser_baud_sel === can_bridge_pkg::SER_BAUD_115200, "config speed");
		repeat (6) filt(rid());
		setcfg(mk(0, 29'h123, 29'h7ff, 0, 0));
		filt(29'h123);
		filt(29'h122);
		filt(29'h523);
		filt(29'h923);
		setcfg(mk(0, 29'h100, 29'h7c0, 0, 0));
		filt(29'h0ff);
		filt(29'h100);
		filt(29'h12f);
		filt(29'h130);
		filt(29'h1c0);
		setcfg(mk(1, 29'h0abcdef0, can_bridge_pkg::EXT_ID_MASK, 0, 0));
		filt(29'h0abcdef0);
		filt(29'h1abcdef0);
		repeat (16) begin
			d = {rnd(), rnd()};
			setcfg(mk(d[40], d[28:0], rid() & rid() & rid(), 0, 0));
			filt(d[28:0] ^ (rid() & rid()));
		end
		// error reply left enabled so that pair mode is what keeps it quiet
		setcfg(mk(0, rid(), '0, 1, 1));
		d = {rnd(), rnd()};
		dl = 4'(rnd() % 8 + 1);
		frame(rid(), dl, d);
		for (n = 0; n < 200 && sq.size() < dl; n++) @(posedge mclk);
		for (int i = 0; i < dl; i++) chk(sq.pop_front() === d[8*i+:8], "pair rx byte");
		chk(fq.size() == 0, "pair rx forwarded");
		d = {rnd(), rnd()};
		for (int i = 0; i < 8; i++) sbyte(d[8*i+:8]);
		for (n = 0; n < 100 && tq.size() == 0; n++) @(posedge mclk);
		c = ~cur[can_bridge_pkg::F_CODE_LSB+:29] & can_bridge_pkg::STD_ID_MASK;
		chk(tq.pop_front() === {1'b0, 4'h8, c, d}, "pair tx frame");
		chk(cq.size() == 0, "pair bytes parsed");
		// a short burst is only sent once the line has been quiet long enough
		for (int i = 0; i < 3; i++) sbyte(d[8*i+:8]);
		for (n = 0; n < 500 && tq.size() == 0; n++) @(posedge mclk);
		tx = tq.pop_front();
		chk(tx[97:64] === {1'b0, 4'h3, c} && tx[23:0] === d[23:0], "idle flush frame");
		pulse_err();
		chk(sq.size() == 0, "pair error reply");
		cur = mk(0, rid(), '0, 1, 0);
		cur[can_bridge_pkg::F_TERM_LSB+:3] = can_bridge_pkg::TERM_RETURN;
		setcfg(cur);
		frame(rid(), 4'h4, 64'h34333231);
		repeat (30) @(posedge mclk);
		chk(sq.size() == 0, "bytes not held");
		frame(rid(), 4'h3, 64'h0d3635);
		d = 64'h000d363534333231;
		for (n = 0; n < 200 && sq.size() < 7; n++) @(posedge mclk);
		for (int i = 0; i < 7; i++) chk(sq.pop_front() === d[8*i+:8], "held byte");
		setcfg(mk(0, '0, '0, 0, 1));
		chk(checksum_enable === 1'b1, "checksum flag");
		sbyte(8'h41);
		// one-byte command, so its trailing checksum byte equals the command byte
		sbyte(8'h41);
		for (n = 0; n < 40 && cq.size() < 2; n++) @(posedge mclk);
		chk(cq.pop_front() === 8'h41, "command byte");
		chk(cq.pop_front() === 8'h41, "checksum byte");
		pulse_err();
		chk(sq.pop_front() === ERR, "error reply");
		setcfg(mk(0, '0, '0, 0, 0));
		pulse_err();
		chk(sq.size() == 0, "reply when off");
		setcfg(mk(1, rid(), rid(), 1, 1));
		@(posedge mclk);
		store_request <= 1;
		@(posedge mclk);
		store_request <= 0;
		#1 chk(nv_wr_valid === 1'b1 && nv_wr_data === cur, "store word");
		for (n = 0; n < 60 && nv_wr_valid !== 1'b0; n++) @(posedge mclk);
		chk(n < 60, "store stuck");
		@(posedge mclk);
		restore_defaults <= 1;
		@(posedge mclk);
		restore_defaults <= 0;
		#1 chk(cfg_q === can_bridge_pkg::CFG_DEFAULT, "restore");
		@(posedge mclk);
		nv_rd_valid <= 1;
		nv_rd_data <= mk(1, 29'h155, 29'h7ff, 0, 1);
		@(posedge mclk);
		nv_rd_valid <= 0;
		#1 chk(cfg_q === mk(1, 29'h155, 29'h7ff, 0, 1), "stored set load");
		@(posedge mclk);
		rst_n <= 0;
		init_switch <= 0;
		repeat (2) @(posedge mclk);
		rst_n <= 1;
		setcfg(mk(0, '0, '0, 0, 0));
		chk(ser_baud_sel === 4'h2, "stored speed");
		end_sim();
	end
endmodule
